/* cds_pkg.sv */
package cds_pkg;

	// ----------------------------------------------------------------
	// register addresses in the direct space
	// ----------------------------------------------------------------
	localparam logic [7:0] SFR_STACK_ADDR = 8'h81;
	localparam logic [7:0] SFR_POWER_ADDR = 8'h87;
	localparam logic [7:0] SFR_PSTORE_ADDR = 8'h8F;

	// ----------------------------------------------------------------
	// values after reset and bit positions
	// ----------------------------------------------------------------
	localparam logic [7:0] STACK_RESET = 8'h07;
	localparam logic [5:0] POWER_GP_RESET = 6'h00;
	localparam logic PSTORE_RESET = 1'b0;
	localparam int POWER_STOP_BIT = 1;
	localparam int POWER_IDLE_BIT = 0;
	localparam int PSTORE_WEN_BIT = 0;

	// ----------------------------------------------------------------
	// data space layout
	// ----------------------------------------------------------------
	localparam int IRAM_BYTES = 256;
	localparam int ON_CHIP_XDATA_RAM_BYTES = 512;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [15:0] CODE_FIRST = 16'h0000;
	localparam logic [15:0] CODE_LAST = 16'h1DFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_PUSH = 2'h2,
		OP_POP = 2'h3
	} cds_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PTR = 2'h1,
		ST_MOD = 2'h3
	} cds_state_t;

endpackage

/* cds_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module cds_ram #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic clkEn,
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] addr,
	input wire logic [WIDTH-1:0] wrData,
	output logic [WIDTH-1:0] rdData
);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("cds_ram: DEPTH must be a power of two and WIDTH positive");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// synchronous write, asynchronous read so a lookup finishes in the cycle it is asked
	always_ff @(posedge sys_clk) begin
		if (clkEn && wrEn) begin
			mem[addr] <= wrData;
		end
	end

	assign rdData = mem[addr];

endmodule
`default_nettype wire

/* cds_power.sv */
`timescale 1ns/1ps
`default_nettype none
module cds_power (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic pconWrite,
	input wire logic wrIdle,
	input wire logic wrStop,
	input wire logic instrDone,
	input wire logic intReq,
	output logic cpuClkOff,
	output logic oscStop
);

	typedef struct packed {
		logic idlePend;
		logic stopPend;
		logic idle;
		logic stop;
	} cds_pwr_t;

	cds_pwr_t cur_ff, nxt_cur;

	// ----------------------------------------------------------------
	// request, arm at end of instruction, wake
	// ----------------------------------------------------------------
	always_comb begin
		nxt_cur = cur_ff;
		if (pconWrite) begin
			nxt_cur.idlePend = cur_ff.idlePend | wrIdle;
			nxt_cur.stopPend = cur_ff.stopPend | wrStop;
		end
		// nothing halts until the writing instruction has completed
		if (instrDone) begin
			nxt_cur.idle = cur_ff.idle | nxt_cur.idlePend | nxt_cur.stopPend;
			nxt_cur.stop = cur_ff.stop | nxt_cur.stopPend;
			nxt_cur.idlePend = 1'b0;
			nxt_cur.stopPend = 1'b0;
		end
		// an interrupt ends sleep but never power-down; only reset does that
		if (intReq && !nxt_cur.stop) begin
			nxt_cur.idle = 1'b0;
			nxt_cur.idlePend = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cur_ff <= '0;
		end else if (clkEn) begin
			cur_ff <= nxt_cur;
		end
	end

	assign cpuClkOff = cur_ff.idle;
	assign oscStop = cur_ff.stop;

endmodule
`default_nettype wire

/* cds_data_space.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - writing one to power bit 1 stops the oscillator; the bit reads zero
// - writing one to power bit 0 gates only the cpu clock; reads zero
// - program flash spans 0x0000 to 0x1DFF; higher code addresses are reserved
// - with program store write enable set, movx writes go to program memory
// - 256 bytes of internal ram cover data addresses 0x00 to 0xFF
// - lower 128 bytes answer both direct and indirect accesses
// - above 0x7F direct goes to sfrs, indirect to upper ram
// - 0x00 to 0x1F hold four register banks chosen by two status bits
// - indirect pointer comes from register 0 or 1 of the active bank
// - bytes 0x20 to 0x2F also form bit addresses 0x00 to 0x7F
// - operand type, not address, chooses bit access versus byte access
// - stack pointer at 0x81 points at last used; push writes pointer plus one
// - reset loads stack pointer with 0x07 so first push lands at 0x08
// - stack may sit anywhere in the 256 bytes, up to full depth
// - every direct access to 0x80 through 0xFF goes to sfr space
// - sfrs ending in 0x0 or 0x8 are bit addressable, others byte only
// - 512 extra on-chip bytes live in external data space, movx only
// - power bits act once the writing instruction has finished
// - an enabled interrupt clears sleep and resumes the cpu
// - power-down ends only by reset
module cds_data_space #(
	parameter int ON_CHIP_XDATA_RAM_DEPTH = cds_pkg::ON_CHIP_XDATA_RAM_BYTES
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic accValid,
	input wire cds_pkg::cds_op_t accOp,
	input wire logic accIndirect,
	input wire logic accBit,
	input wire logic accPtrSel,
	input wire logic [7:0] accAddr,
	input wire logic [7:0] accWrData,
	input wire logic bankSelectLow,
	input wire logic bankSelectHigh,
	output logic accDone,
	output logic [7:0] accRdData,
	output logic sfrRdEn,
	output logic sfrWrEn,
	output logic [7:0] sfrAddr,
	output logic [7:0] sfrWrData,
	input wire logic [7:0] sfrRdData,
	input wire logic xReq,
	input wire logic xWrite,
	input wire logic [15:0] xAddr,
	input wire logic [7:0] xWrData,
	output logic xDone,
	output logic [7:0] xRdData,
	output logic codeWrEn,
	output logic [15:0] codeAddr,
	output logic [7:0] codeWrData,
	input wire logic instrDone,
	input wire logic intReq,
	output logic cpuClkOff,
	output logic oscStop,
	output logic [7:0] stackTopPointer,
	output logic progWriteEn
);

	localparam int XAW = $clog2(ON_CHIP_XDATA_RAM_DEPTH);

	// elaboration checks: on_chip_xdata_ram depth is fixed, and the power mode bit positions must not lie above bit 1
	initial begin
		if (ON_CHIP_XDATA_RAM_DEPTH != cds_pkg::ON_CHIP_XDATA_RAM_BYTES)
			$error("cds_data_space: on-chip xdata ram depth is fixed by the memory map");
		if (cds_pkg::POWER_STOP_BIT > 1 || cds_pkg::POWER_IDLE_BIT > 1)
			$error("cds_data_space: power mode bits must be bits 1 and 0");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// one record holds every register of the block except those of the power unit, outputs included
	typedef struct packed {
		cds_pkg::cds_state_t st;
		cds_pkg::cds_op_t op;
		logic isBit;
		logic isRam;
		logic [2:0] bitPos;
		logic [7:0] ea;
		logic [7:0] wdata;
		logic [7:0] sp;
		logic [5:0] pconGp;
		logic psWen;
		logic [7:0] ramAddr;
		logic ramWe;
		logic [7:0] ramWd;
		logic sfrRd;
		logic sfrWr;
		logic [7:0] sfrAd;
		logic [7:0] sfrWd;
		logic done;
		logic [7:0] rdData;
		logic xDone;
		logic [7:0] xRd;
		logic codeWr;
		logic [15:0] codeAd;
		logic [7:0] codeWd;
	} cds_core_t;

	cds_core_t cur_ff, nxt_cur;

	logic [7:0] ramRd;
	logic [7:0] xramRd;
	logic xramWe;
	logic pconWrite;
	logic [7:0] src;
	logic [7:0] newByte;
	logic [7:0] bankReg;

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------

	// byte holding a given bit address: bit area below 0x80, sfr above
	function automatic logic [7:0] bitByteAddr(input logic [7:0] b);
		if (b[7]) begin
			return {b[7:3], 3'h0};
		end
		return cds_pkg::BIT_AREA_BASE + {4'h0, b[6:3]};
	endfunction

	// sfrs held in this block rather than in peripherals
	function automatic logic isLocalSfr(input logic [7:0] a);
		return a == cds_pkg::SFR_STACK_ADDR || a == cds_pkg::SFR_POWER_ADDR ||
			a == cds_pkg::SFR_PSTORE_ADDR;
	endfunction

	// address of working register 0 or 1 in the active bank
	assign bankReg = {3'h0, bankSelectHigh, bankSelectLow, 2'h0, accPtrSel};

	// ----------------------------------------------------------------
	// memories
	// ----------------------------------------------------------------

	// one array serves lower and upper ram; sfrs never reach it by direct access
	cds_ram #(
		.DEPTH(cds_pkg::IRAM_BYTES),
		.WIDTH(8)
	) u_iram (
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(cur_ff.ramWe),
		.addr(cur_ff.ramAddr),
		.wrData(cur_ff.ramWd),
		.rdData(ramRd)
	);

	// xdata writes bypass this ram while program store writes are enabled
	assign xramWe = xReq && xWrite && !cur_ff.psWen && xAddr < 16'(ON_CHIP_XDATA_RAM_DEPTH);

	cds_ram #(
		.DEPTH(ON_CHIP_XDATA_RAM_DEPTH),
		.WIDTH(8)
	) u_on_chip_xdata_ram (
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(xramWe),
		.addr(xAddr[XAW-1:0]),
		.wrData(xWrData),
		.rdData(xramRd)
	);

	// ----------------------------------------------------------------
	// source byte and merged byte for the modify step
	// ----------------------------------------------------------------
	always_comb begin
		if (cur_ff.isRam) begin
			src = ramRd;
		end else if (cur_ff.ea == cds_pkg::SFR_STACK_ADDR) begin
			src = cur_ff.sp;
		end else if (cur_ff.ea == cds_pkg::SFR_POWER_ADDR) begin
			src = {cur_ff.pconGp, 2'h0};
		end else if (cur_ff.ea == cds_pkg::SFR_PSTORE_ADDR) begin
			src = {7'h00, cur_ff.psWen};
		end else begin
			src = sfrRdData;
		end
		// a bit write merges one bit into the byte it lives in
		if (cur_ff.isBit) begin
			newByte = (src & ~(8'h01 << cur_ff.bitPos)) | ({7'h00, cur_ff.wdata[0]} << cur_ff.bitPos);
		end else begin
			newByte = cur_ff.wdata;
		end
	end

	// ----------------------------------------------------------------
	// access sequencer and movx routing
	// ----------------------------------------------------------------
	// a direct access is taken in idle, modifies one cycle later and reports done
	// the cycle after; indirect adds one pointer fetch cycle in between
	// ram writes land at the edge that closes the done cycle, so an access taken
	// in that cycle already reads the new byte
	always_comb begin
		nxt_cur = cur_ff;
		pconWrite = 1'b0;
		nxt_cur.ramWe = 1'b0;
		nxt_cur.sfrWr = 1'b0;
		nxt_cur.sfrRd = 1'b0;
		nxt_cur.done = 1'b0;
		nxt_cur.xDone = 1'b0;
		nxt_cur.codeWr = 1'b0;
		unique case (cur_ff.st)
			cds_pkg::ST_IDLE: begin
				if (accValid) begin
					nxt_cur.op = accOp;
					nxt_cur.wdata = accWrData;
					nxt_cur.isBit = 1'b0;
					nxt_cur.bitPos = 3'h0;
					nxt_cur.isRam = 1'b1;
					nxt_cur.st = cds_pkg::ST_MOD;
					if (accOp == cds_pkg::OP_PUSH) begin
						// stack lives in the indirect space, so it may use all 256 bytes
						nxt_cur.ramAddr = cur_ff.sp + 8'h01;
						nxt_cur.ea = cur_ff.sp + 8'h01;
						nxt_cur.sp = cur_ff.sp + 8'h01;
					end else if (accOp == cds_pkg::OP_POP) begin
						nxt_cur.ramAddr = cur_ff.sp;
						nxt_cur.ea = cur_ff.sp;
						nxt_cur.sp = cur_ff.sp - 8'h01;
					end else if (accIndirect) begin
						// fetch the pointer first; the target is always ram
						nxt_cur.ramAddr = bankReg;
						nxt_cur.st = cds_pkg::ST_PTR;
					end else begin
						// operand type alone picks bit or byte handling
						nxt_cur.isBit = accBit;
						nxt_cur.ea = accBit ? bitByteAddr(accAddr) : accAddr;
						nxt_cur.bitPos = accBit ? accAddr[2:0] : 3'h0;
						nxt_cur.isRam = !accAddr[7];
						nxt_cur.ramAddr = nxt_cur.ea;
						nxt_cur.sfrAd = nxt_cur.ea;
						// peripheral sfrs get a read strobe only when the old byte is needed:
						// a plain byte write must not fire it, since a read may clear a flag
						nxt_cur.sfrRd = accAddr[7] && !isLocalSfr(nxt_cur.ea) &&
							(accOp == cds_pkg::OP_READ || accBit);
					end
				end
			end
			cds_pkg::ST_PTR: begin
				// the pointer may be above 0x7F; indirect reaches upper ram there
				nxt_cur.ramAddr = ramRd;
				nxt_cur.ea = ramRd;
				nxt_cur.st = cds_pkg::ST_MOD;
			end
			cds_pkg::ST_MOD: begin
				nxt_cur.rdData = cur_ff.isBit ? {7'h00, src[cur_ff.bitPos]} : src;
				nxt_cur.done = 1'b1;
				nxt_cur.st = cds_pkg::ST_IDLE;
				if (cur_ff.op == cds_pkg::OP_WRITE || cur_ff.op == cds_pkg::OP_PUSH) begin
					if (cur_ff.isRam) begin
						nxt_cur.ramWe = 1'b1;
						nxt_cur.ramWd = newByte;
					end else if (cur_ff.ea == cds_pkg::SFR_STACK_ADDR) begin
						nxt_cur.sp = newByte;
					end else if (cur_ff.ea == cds_pkg::SFR_POWER_ADDR) begin
						// mode bits are not stored; they only raise requests
						nxt_cur.pconGp = newByte[7:2];
						pconWrite = 1'b1;
					end else if (cur_ff.ea == cds_pkg::SFR_PSTORE_ADDR) begin
						nxt_cur.psWen = newByte[cds_pkg::PSTORE_WEN_BIT];
					end else begin
						// unoccupied sfr addresses are passed on unchecked
						nxt_cur.sfrWr = 1'b1;
						nxt_cur.sfrWd = newByte;
					end
				end
			end
			default: begin
				nxt_cur.st = cds_pkg::ST_IDLE;
			end
		endcase

		// movx runs beside the data sequencer and finishes in one cycle
		// reads below 0x200 come from on-chip on_chip_xdata_ram, higher ones return zero; program memory is not readable this way
		if (xReq) begin
			nxt_cur.xDone = 1'b1;
			nxt_cur.xRd = xAddr < 16'(ON_CHIP_XDATA_RAM_DEPTH) ? xramRd : 8'h00;
			if (xWrite && cur_ff.psWen && xAddr <= cds_pkg::CODE_LAST) begin
				nxt_cur.codeWr = 1'b1;
				nxt_cur.codeAd = xAddr - cds_pkg::CODE_FIRST;
				nxt_cur.codeWd = xWrData;
			end
		end
	end

	// synchronous reset; clkEn low holds every register, ram writes included
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cur_ff <= '0;
			cur_ff.st <= cds_pkg::ST_IDLE;
			cur_ff.op <= cds_pkg::OP_READ;
			cur_ff.sp <= cds_pkg::STACK_RESET;
			cur_ff.pconGp <= cds_pkg::POWER_GP_RESET;
			cur_ff.psWen <= cds_pkg::PSTORE_RESET;
		end else if (clkEn) begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------------------------------
	// power control
	// ----------------------------------------------------------------
	// the mode bits reach the power unit unregistered, in the very cycle of the write
	cds_power u_power (
		.sys_clk(sys_clk),
		.reset(reset),
		.clkEn(clkEn),
		.pconWrite(pconWrite),
		.wrIdle(newByte[cds_pkg::POWER_IDLE_BIT]),
		.wrStop(newByte[cds_pkg::POWER_STOP_BIT]),
		.instrDone(instrDone),
		.intReq(intReq),
		.cpuClkOff(cpuClkOff),
		.oscStop(oscStop)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every output but cpuClkOff and oscStop is a field of the state record; those two come from the power unit's flops, so all come straight from flops
	assign accDone = cur_ff.done;
	assign accRdData = cur_ff.rdData;
	assign sfrRdEn = cur_ff.sfrRd;
	assign sfrWrEn = cur_ff.sfrWr;
	assign sfrAddr = cur_ff.sfrAd;
	assign sfrWrData = cur_ff.sfrWd;
	assign xDone = cur_ff.xDone;
	assign xRdData = cur_ff.xRd;
	assign codeWrEn = cur_ff.codeWr;
	assign codeAddr = cur_ff.codeAd;
	assign codeWrData = cur_ff.codeWd;
	assign stackTopPointer = cur_ff.sp;
	assign progWriteEn = cur_ff.psWen;

endmodule
`default_nettype wire

/* cds_data_space_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module cds_data_space_sva (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic accDone,
	input wire logic sfrRdEn,
	input wire logic sfrWrEn,
	input wire logic xReq,
	input wire logic xWrite,
	input wire logic [15:0] xAddr,
	input wire logic xDone,
	input wire logic [7:0] xRdData,
	input wire logic codeWrEn,
	input wire logic [15:0] codeAddr,
	input wire logic progWriteEn,
	input wire logic instrDone,
	input wire logic intReq,
	input wire logic cpuClkOff,
	input wire logic oscStop,
	input wire logic [7:0] stackTopPointer
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// pointer leaves reset at its documented start value
	sp_reset_a: assert property ($fell(reset) |-> stackTopPointer == 8'h07)
		else $error("stack pointer not at reset value");
	sfr_read_a: assert property (sfrRdEn |=> accDone)
		else $error("sfr read not completed next cycle");
	sfr_write_a: assert property (sfrWrEn |-> accDone)
		else $error("sfr write outside completion cycle");
	movx_answer_a: assert property (xReq |=> xDone)
		else $error("movx not answered next cycle");
	on_chip_xdata_ram_above_a: assert property (xReq && !xWrite && xAddr >= 16'h0200 |=> xRdData == 8'h00)
		else $error("read above on-chip xdata not zero");
	code_write_a: assert property (xReq && xWrite && progWriteEn && xAddr <= 16'h1DFF
		|=> codeWrEn && codeAddr == $past(xAddr))
		else $error("program store write not forwarded");
	code_resv_a: assert property (xReq && xWrite && progWriteEn && xAddr > 16'h1DFF |=> !codeWrEn)
		else $error("reserved code address written");
	sleep_start_a: assert property ($rose(cpuClkOff) |-> $past(instrDone))
		else $error("cpu clock gated before instruction end");
	sleep_wake_a: assert property (intReq && cpuClkOff && !oscStop |=> !cpuClkOff)
		else $error("interrupt did not resume cpu");
	stop_hold_a: assert property (oscStop |=> oscStop && cpuClkOff)
		else $error("power-down left without reset");
endmodule
bind cds_data_space cds_data_space_sva i_sva (.sys_clk, .reset, .accDone, .sfrRdEn, .sfrWrEn, .xReq, .xWrite,
	.xAddr, .xDone, .xRdData, .codeWrEn, .codeAddr, .progWriteEn, .instrDone, .intReq, .cpuClkOff, .oscStop,
	.stackTopPointer);
`default_nettype wire

/* cds_sfr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// peripheral registers answering the sfr strobes
module cds_sfr_model (
	input wire logic sys_clk,
	input wire logic sfrRdEn,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData
);
	logic [7:0] mem [256];
	logic [7:0] lastRd;
	// each location starts at its own address so reads are traceable
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i);
		lastRd = 8'h00;
	end
	// outside the strobe the bus shows junk, so a late sample is caught
	always_comb sfrRdData = sfrRdEn ? mem[sfrAddr] : ~lastRd;
	always @(posedge sys_clk) begin
		if (sfrRdEn) lastRd <= mem[sfrAddr];
		if (sfrWrEn) mem[sfrAddr] <= sfrWrData;
	end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk, reset, accValid, accIndirect, accBit, accPtrSel, bankSelectLow, bankSelectHigh;
	logic xReq, xWrite, instrDone, intReq, accDone, sfrRdEn, sfrWrEn, xDone, codeWrEn;
	logic cpuClkOff, oscStop, progWriteEn;
	cds_pkg::cds_op_t accOp;
	logic [7:0] accAddr, accWrData, xWrData, accRdData, sfrAddr, sfrWrData, sfrRdData, xRdData;
	logic [7:0] codeWrData, stackTopPointer;
	logic [15:0] xAddr, codeAddr;
	int errors, nCompared;

	cds_data_space i_dut (.sys_clk, .reset, .clkEn(1'h1), .accValid, .accOp, .accIndirect, .accBit, .accPtrSel,
		.accAddr, .accWrData, .bankSelectLow, .bankSelectHigh, .accDone, .accRdData, .sfrRdEn, .sfrWrEn, .sfrAddr,
		.sfrWrData, .sfrRdData, .xReq, .xWrite, .xAddr, .xWrData, .xDone, .xRdData, .codeWrEn, .codeAddr,
		.codeWrData, .instrDone, .intReq, .cpuClkOff, .oscStop, .stackTopPointer, .progWriteEn);
	cds_sfr_model i_sfr (.sys_clk, .sfrRdEn, .sfrWrEn, .sfrAddr, .sfrWrData, .sfrRdData);

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic stop_test;
		$display("errors %0d compared %0d", errors, nCompared);
		if (errors == 0 && nCompared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	// one data-space access; bt also picks R1 when indirect, since bit is ignored there
	task automatic acc(input cds_pkg::cds_op_t op, input logic ind, input logic bt, input logic [7:0] a, d);
		int n;
		@(posedge sys_clk);
		accValid <= 1'h1;
		accOp <= op;
		accIndirect <= ind;
		accBit <= bt;
		accPtrSel <= bt;
		accAddr <= a;
		accWrData <= d;
		@(posedge sys_clk);
		accValid <= 1'h0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (accDone !== 1'h1 && n < 8);
		if (accDone !== 1'h1) begin
			$display("unexpected accDone: expected 1 seen %b", accDone);
			errors++;
			stop_test;
		end
	endtask

	// one movx; returns in the answer cycle
	task automatic mx(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		xReq <= 1'h1;
		xWrite <= w;
		xAddr <= a;
		xWrData <= d;
		@(posedge sys_clk);
		xReq <= 1'h0;
		#1;
	endtask

	task automatic pulse(input logic intr);
		@(posedge sys_clk);
		if (intr) intReq <= 1'h1;
		else instrDone <= 1'h1;
		@(posedge sys_clk);
		intReq <= 1'h0;
		instrDone <= 1'h0;
		#1;
	endtask

	task automatic t_banks;
		@(posedge sys_clk);
		bankSelectHigh <= 1'h1;
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h30, 8'hA5);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h11, 8'h30);
		acc(cds_pkg::OP_READ, 1'h1, 1'h1, 8'h00, 8'h00);
		chk("bank ptr read", 8'hA5, accRdData);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h11, 8'h90);
		acc(cds_pkg::OP_WRITE, 1'h1, 1'h1, 8'h00, 8'h3C);
		acc(cds_pkg::OP_READ, 1'h0, 1'h0, 8'h90, 8'h00);
		chk("direct sfr read", 8'h90, accRdData);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h90, 8'h77);
		@(posedge sys_clk);
		#1;
		chk("sfr write", 8'h77, i_sfr.mem[8'h90]);
		acc(cds_pkg::OP_READ, 1'h1, 1'h1, 8'h00, 8'h00);
		chk("upper ram", 8'h3C, accRdData);
		@(posedge sys_clk);
		bankSelectLow <= 1'h1;
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h18, 8'h30);
		acc(cds_pkg::OP_READ, 1'h1, 1'h0, 8'h00, 8'h00);
		chk("bank3 r0 read", 8'hA5, accRdData);
	endtask

	task automatic t_bits;
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h22, 8'h00);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h1, 8'h13, 8'h01);
		acc(cds_pkg::OP_READ, 1'h0, 1'h0, 8'h22, 8'h00);
		chk("bit area byte", 8'h08, accRdData);
		acc(cds_pkg::OP_READ, 1'h0, 1'h1, 8'h13, 8'h00);
		chk("bit read", 8'h01, accRdData);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h1, 8'h89, 8'h01);
		@(posedge sys_clk);
		#1;
		chk("sfr bit write", 8'h8A, i_sfr.mem[8'h88]);
	endtask

	task automatic t_stack;
		acc(cds_pkg::OP_PUSH, 1'h0, 1'h0, 8'h00, 8'h5A);
		chk("sp after push", 8'h08, stackTopPointer);
		acc(cds_pkg::OP_READ, 1'h0, 1'h0, 8'h08, 8'h00);
		chk("pushed byte", 8'h5A, accRdData);
		acc(cds_pkg::OP_POP, 1'h0, 1'h0, 8'h00, 8'h00);
		chk("popped byte", 8'h5A, accRdData);
		chk("sp after pop", 8'h07, stackTopPointer);
	endtask

	task automatic t_movx;
		mx(1'h1, 16'h01FF, 8'h3C);
		mx(1'h0, 16'h01FF, 8'h00);
		chk("on_chip_xdata_ram read", 9'h13C, {xDone, xRdData});
		mx(1'h0, 16'h0200, 8'h00);
		chk("on_chip_xdata_ram above", 8'h00, xRdData);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h8F, 8'h01);
		chk("store enable", 1'h1, progWriteEn);
		mx(1'h1, 16'h1DFF, 8'h99);
		chk("code write", 25'h11DFF99, {codeWrEn, codeAddr, codeWrData});
		mx(1'h1, 16'h01FF, 8'h66);
		chk("code write low", 25'h101FF66, {codeWrEn, codeAddr, codeWrData});
		mx(1'h1, 16'h1E00, 8'h11);
		chk("reserved code", 1'h0, codeWrEn);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h8F, 8'h00);
		mx(1'h0, 16'h01FF, 8'h00);
		chk("on_chip_xdata_ram kept", 8'h3C, xRdData);
	endtask

	task automatic t_power;
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h87, 8'hFD);
		chk("sleep early", 1'h0, cpuClkOff);
		pulse(1'h0);
		chk("sleep", 2'h1, {oscStop, cpuClkOff});
		pulse(1'h1);
		chk("wake", 1'h0, cpuClkOff);
		acc(cds_pkg::OP_READ, 1'h0, 1'h0, 8'h87, 8'h00);
		chk("power readback", 8'hFC, accRdData);
		acc(cds_pkg::OP_WRITE, 1'h0, 1'h0, 8'h87, 8'h02);
		pulse(1'h0);
		pulse(1'h1);
		chk("stop", 2'h3, {oscStop, cpuClkOff});
		@(posedge sys_clk);
		reset <= 1'h1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		#1;
		chk("after reset", 10'h007, {oscStop, cpuClkOff, stackTopPointer});
	endtask

	initial begin
		errors = 0;
		nCompared = 0;
		{reset, accValid, accIndirect, accBit, accPtrSel, bankSelectLow, bankSelectHigh} = 7'h40;
		{xReq, xWrite, instrDone, intReq, accAddr, accWrData, xWrData, xAddr} = 44'h0;
		accOp = cds_pkg::OP_READ;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		#1;
		chk("reset state", 11'h007, {oscStop, cpuClkOff, progWriteEn, stackTopPointer});
		t_banks;
		t_bits;
		t_stack;
		t_movx;
		t_power;
		stop_test;
	end
endmodule
`default_nettype wire
